// ### pkg/fpw_cfg.svh
// Offsets, reset values, field positions and timing figures of the watchdog
`ifndef FPW_CFG_SVH
`define FPW_CFG_SVH

// Register offsets on the register port
`define FPW_OFF_MULT 16'h0400
`define FPW_OFF_PDI_TIME 16'h0410
`define FPW_OFF_BUS_TIME 16'h0420
`define FPW_OFF_SAFE_VAL 16'h0430
`define FPW_OFF_STATUS 16'h0440

// Reset values: 2498 and 1000 give a 100 ms timeout
`define FPW_RST_MULT 16'h09C2
`define FPW_RST_TIME 16'h03E8
`define FPW_RST_SAFE 4'h0

// Status register bit positions
`define FPW_ST_PDI_BIT 0
`define FPW_ST_BUS_BIT 1

// Prescaler: one watchdog tick is (multiplier + 2) base ticks of 40 ns
`define FPW_MULT_OFFSET 23'h000002
`define FPW_BASE_TICK_NS 23'h000028
`define FPW_CLK_PERIOD_NS 32'h00000032

// Indicator timing: 50 ms slots, 24 slots per pattern, 4 slots per flash
`define FPW_LED_SLOT_NS 32'h02FAF080
`define FPW_LED_SLOTS 5'h18
`define FPW_FLASH_SLOTS 5'h04

`endif

// ### pkg/fpw_pkg.sv
// Types shared by the watchdog modules
package fpw_pkg;

    // State machine state as reported by the slave controller, Gray coded
    typedef enum logic [2:0] {
        FPW_ESM_INIT = 3'h0,
        FPW_ESM_PREOP = 3'h1,
        FPW_ESM_SAFEOP = 3'h3,
        FPW_ESM_OP = 3'h2,
        FPW_ESM_BOOT = 3'h6
    } fpw_esm_t;

    // All state of the prescaler
    typedef struct packed {
        logic [22:0] acc;
        logic tick;
    } fpw_pre_st_t;

    // All state of the watchdog top
    typedef struct packed {
        logic [15:0] mult;
        logic [15:0] pdi_time;
        logic [15:0] bus_time;
        logic [3:0] safe_val;
        logic [15:0] pdi_elapsed;
        logic [15:0] bus_elapsed;
        logic pdi_fired;
        logic bus_fired;
        logic [19:0] led_cnt;
        logic [4:0] led_slot;
        logic run_led;
        logic [3:0] out_data;
        logic [3:0] chan_led;
        logic [15:0] rdata;
        logic rvalid;
    } fpw_top_st_t;

endpackage : fpw_pkg

// ### pkg/fpw_tick_if.sv
// Carrier between the top and the shared prescaler
`timescale 1ns/10ps
interface fpw_tick_if;
    logic [15:0] mult; // Shared multiplier value
    logic tick; // One-cycle pulse per watchdog tick

    modport src (input mult, output tick);
    modport user (output mult, input tick);
endinterface : fpw_tick_if

// ### src/fpw_prescaler.sv
// Shared prescaler that turns the system clock into watchdog ticks
`timescale 1ns/10ps
`include "fpw_cfg.svh"
module fpw_prescaler
    import fpw_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    fpw_tick_if.src tick_bus
);

    fpw_pre_st_t st_reg; // Registered state
    fpw_pre_st_t st_next; // Next state
    logic [22:0] tick_ns; // Length of one watchdog tick in ns
    logic [22:0] sum_ns; // Accumulated time after this clock
    logic [22:0] diff_ns; // Remainder after a tick
    logic [22:0] clk_ns; // Clock period in ns

    assign clk_ns = 23'(`FPW_CLK_PERIOD_NS);
    assign tick_bus.tick = st_reg.tick;

    // The clock is not a multiple of 40 ns, so time is kept in ns and
    // the remainder carried; the long-run rate is exact, jitter one clock
    always_comb
    begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        tick_ns = (23'(tick_bus.mult) + `FPW_MULT_OFFSET)
            * `FPW_BASE_TICK_NS;
        sum_ns = st_reg.acc + clk_ns;
        diff_ns = sum_ns - tick_ns;
        if (sum_ns >= tick_ns)
        begin
            st_next.tick = 1'b1;
            // A shrunk multiplier must not leave a backlog of ticks
            st_next.acc = (diff_ns < clk_ns) ? diff_ns : 23'h000000;
        end
        else
        begin
            st_next.acc = sum_ns;
        end
    end

    // State register
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // After a tick less than one clock period of time is left over
    a_tick_remainder: assert property (@(posedge i_clock)
        disable iff (i_sys_rst)
        st_reg.tick |-> st_reg.acc < clk_ns)
        else $error("prescaler remainder too large after tick");

endmodule : fpw_prescaler

// ### src/fpw_top.sv
// Bus-side and process-interface watchdogs with safe outputs and indicators
`timescale 1ns/10ps
`include "fpw_cfg.svh"
module fpw_top
    import fpw_pkg::*;
#(
    // Clock cycles per 50 ms indicator slot
    parameter int unsigned P_LED_SLOT_CYCLES =
        `FPW_LED_SLOT_NS / `FPW_CLK_PERIOD_NS
)
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_pd_exchange,
    input wire logic i_pdi_access,
    input wire logic [2:0] i_esm_state,
    input wire logic [3:0] i_out_data,
    output logic [3:0] o_out_data,
    output logic [3:0] o_chan_led,
    output logic o_run_led,
    output logic o_bus_wd_expired,
    output logic o_pdi_wd_expired
);

    fpw_top_st_t st_reg; // Registered state
    fpw_top_st_t st_next; // Next state
    fpw_esm_t esm; // Decoded slave state
    logic [16:0] pdi_step; // Next fired flag and count, interface side
    logic [16:0] bus_step; // Next fired flag and count, bus side
    logic force_safe; // Outputs must show the safe value
    logic slot_end; // Last cycle of an indicator slot

    fpw_tick_if tick_bus (); // Link to the shared prescaler

    // Address match, used by both the write and the read decode
    function automatic logic fpw_hit(input logic [15:0] addr,
        input logic [15:0] off);
        return addr == off;
    endfunction : fpw_hit

    // One watchdog step: a restart zeroes the count and clears the flag;
    // a zero limit stops counting; the flag holds until the next restart
    function automatic logic [16:0] fpw_wd_step(input logic restart,
        input logic tick, input logic [15:0] limit,
        input logic [15:0] elapsed, input logic fired);
        logic [15:0] e_next;
        logic f_next;
        e_next = elapsed;
        f_next = fired;
        if (restart)
        begin
            // Restart wins; the count cannot expire in the same cycle
            e_next = 16'h0000;
            f_next = 1'b0;
        end
        else if (tick && (limit != 16'h0000) && !fired)
        begin
            e_next = elapsed + 16'h0001;
            // Greater-or-equal also catches a limit lowered below the count
            if (e_next >= limit)
            begin
                f_next = 1'b1;
            end
        end
        return {f_next, e_next};
    endfunction : fpw_wd_step

    // Shared prescaler, one tick stream for both watchdogs
    fpw_prescaler fpw_prescaler_inst (
        .i_clock (i_clock),
        .i_sys_rst (i_sys_rst),
        .tick_bus (tick_bus.src)
    );

    assign tick_bus.mult = st_reg.mult;
    assign esm = fpw_esm_t'(i_esm_state);
    assign slot_end = (st_reg.led_cnt == 20'(P_LED_SLOT_CYCLES - 1));

    // Outputs straight from the state register
    assign o_reg_rdata = st_reg.rdata;
    assign o_reg_rvalid = st_reg.rvalid;
    assign o_out_data = st_reg.out_data;
    assign o_chan_led = st_reg.chan_led;
    assign o_run_led = st_reg.run_led;
    assign o_bus_wd_expired = st_reg.bus_fired;
    assign o_pdi_wd_expired = st_reg.pdi_fired;

    // Watchdog steps; a 16-bit count of ticks up to 65537 x 40 ns each
    // reaches roughly 172 s, the full range of both registers
    assign pdi_step = fpw_wd_step(i_pdi_access, tick_bus.tick,
        st_reg.pdi_time, st_reg.pdi_elapsed, st_reg.pdi_fired);
    assign bus_step = fpw_wd_step(i_pd_exchange, tick_bus.tick,
        st_reg.bus_time, st_reg.bus_elapsed, st_reg.bus_fired);

    // Safe outputs on any expiry and in every state short of operational
    assign force_safe = st_reg.bus_fired || st_reg.pdi_fired
        || (esm != FPW_ESM_OP);

    // Next-state logic: registers, watchdogs, indicators and outputs
    always_comb
    begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;

        // Register writes; settings keep their value unless written
        if (i_reg_wr)
        begin
            if (fpw_hit(i_reg_addr, `FPW_OFF_MULT))
            begin
                st_next.mult = i_reg_wdata;
            end
            else if (fpw_hit(i_reg_addr, `FPW_OFF_PDI_TIME))
            begin
                st_next.pdi_time = i_reg_wdata;
            end
            else if (fpw_hit(i_reg_addr, `FPW_OFF_BUS_TIME))
            begin
                st_next.bus_time = i_reg_wdata;
            end
            else if (fpw_hit(i_reg_addr, `FPW_OFF_SAFE_VAL))
            begin
                st_next.safe_val = i_reg_wdata[3:0];
            end
        end

        // Register reads, answered one cycle later; unmapped reads zero
        if (i_reg_rd)
        begin
            st_next.rvalid = 1'b1;
            if (fpw_hit(i_reg_addr, `FPW_OFF_MULT))
            begin
                st_next.rdata = st_reg.mult;
            end
            else if (fpw_hit(i_reg_addr, `FPW_OFF_PDI_TIME))
            begin
                st_next.rdata = st_reg.pdi_time;
            end
            else if (fpw_hit(i_reg_addr, `FPW_OFF_BUS_TIME))
            begin
                st_next.rdata = st_reg.bus_time;
            end
            else if (fpw_hit(i_reg_addr, `FPW_OFF_SAFE_VAL))
            begin
                st_next.rdata = {12'h000, st_reg.safe_val};
            end
            else if (fpw_hit(i_reg_addr, `FPW_OFF_STATUS))
            begin
                st_next.rdata = 16'h0000;
                st_next.rdata[`FPW_ST_PDI_BIT] = st_reg.pdi_fired;
                st_next.rdata[`FPW_ST_BUS_BIT] = st_reg.bus_fired;
            end
            else
            begin
                st_next.rdata = 16'h0000;
            end
        end

        // Watchdog counters and sticky expiry flags; only an exchange
        // clears the bus flag, and a zero timer keeps it from rising
        st_next.pdi_fired = pdi_step[16];
        st_next.pdi_elapsed = pdi_step[15:0];
        st_next.bus_fired = bus_step[16];
        st_next.bus_elapsed = bus_step[15:0];

        // Expiry flags and forces the safe value; the state input is read here, never changed

        // Indicator slot timer
        if (slot_end)
        begin
            st_next.led_cnt = 20'h00000;
            if (st_reg.led_slot == (`FPW_LED_SLOTS - 5'h01))
            begin
                st_next.led_slot = 5'h00;
            end
            else
            begin
                st_next.led_slot = st_reg.led_slot + 5'h01;
            end
        end
        else
        begin
            st_next.led_cnt = st_reg.led_cnt + 20'h00001;
        end

        // Run indicator pattern per slave state
        case (esm)
            FPW_ESM_INIT: st_next.run_led = 1'b0;
            FPW_ESM_PREOP: st_next.run_led = !st_reg.led_slot[2];
            FPW_ESM_SAFEOP:
                st_next.run_led = st_reg.led_slot < `FPW_FLASH_SLOTS;
            FPW_ESM_OP: st_next.run_led = 1'b1;
            FPW_ESM_BOOT: st_next.run_led = st_reg.led_slot[0];
            default: st_next.run_led = 1'b0;
        endcase

        // Outputs and their channel indicators
        if (force_safe)
        begin
            st_next.out_data = st_reg.safe_val;
        end
        else
        begin
            st_next.out_data = i_out_data;
        end
        st_next.chan_led = st_next.out_data;
    end

    // State register; settings come out of reset at their defaults
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_reg <= '0;
            st_reg.mult <= `FPW_RST_MULT;
            st_reg.pdi_time <= `FPW_RST_TIME;
            st_reg.bus_time <= `FPW_RST_TIME;
            st_reg.safe_val <= `FPW_RST_SAFE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    // Bus flag rises only on a tick with a nonzero timer, count at or past limit;
    // the limit is the one in force when the step was taken
    a_bus_fire_cause: assert property ($rose(st_reg.bus_fired) |->
        $past(tick_bus.tick) && ($past(st_reg.bus_time) != 16'h0000)
        && (st_reg.bus_elapsed >= $past(st_reg.bus_time)))
        else $error("bus watchdog fired without cause");

    // A zero bus timer never lets the flag rise
    a_bus_zero_off: assert property ((st_reg.bus_time == 16'h0000)
        && $stable(st_reg.bus_time) |-> !$rose(st_reg.bus_fired))
        else $error("disabled bus watchdog fired");

    // Exchange clears bus flag and count next cycle
    a_bus_restart: assert property (i_pd_exchange |=>
        !st_reg.bus_fired && (st_reg.bus_elapsed == 16'h0000))
        else $error("exchange did not restart bus watchdog");

    // Bus flag stays set until an exchange
    a_bus_sticky: assert property (st_reg.bus_fired
        && !i_pd_exchange |=> st_reg.bus_fired)
        else $error("bus expiry flag dropped without exchange");

    // Interface flag rises only on a tick with a nonzero timer
    a_pdi_fire_cause: assert property ($rose(st_reg.pdi_fired) |->
        $past(tick_bus.tick) && ($past(st_reg.pdi_time) != 16'h0000)
        && (st_reg.pdi_elapsed >= $past(st_reg.pdi_time))
        && !$past(i_pdi_access))
        else $error("interface watchdog fired without cause");

    // Any expiry forces the safe value one cycle on
    a_safe_on_fire: assert property ((st_reg.bus_fired
        || st_reg.pdi_fired) |=> o_out_data == $past(st_reg.safe_val))
        else $error("outputs not safe after expiry");

    // Safe-operational holds outputs safe
    a_safeop_hold: assert property ((esm == FPW_ESM_SAFEOP)
        |=> o_out_data == $past(st_reg.safe_val))
        else $error("outputs not safe in safe-operational");

    // Run indicator steady in operational
    a_run_pattern: assert property ((esm == FPW_ESM_OP) ##1
        (esm == FPW_ESM_OP) |-> o_run_led)
        else $error("run indicator not on in operational");

    // Run indicator dark one cycle after init is seen
    a_run_dark: assert property ((esm == FPW_ESM_INIT)
        |=> !o_run_led)
        else $error("run indicator lit in init");

    // Channel indicators follow the driven outputs
    a_chan_follow: assert property ($changed(o_out_data) |->
        o_chan_led == o_out_data)
        else $error("channel indicator mismatch");

    // A multiplier write is seen by the prescaler next cycle
    a_mult_write: assert property (i_reg_wr
        && fpw_hit(i_reg_addr, `FPW_OFF_MULT)
        |=> tick_bus.mult == $past(i_reg_wdata))
        else $error("multiplier write lost");

    // A bus timer write lands in the bus timer register
    a_time_write: assert property (i_reg_wr
        && fpw_hit(i_reg_addr, `FPW_OFF_BUS_TIME)
        |=> st_reg.bus_time == $past(i_reg_wdata))
        else $error("bus timer write lost");

endmodule : fpw_top

// ### tb/fpw_far_model.sv
// Far-side model: bus master exchanges and local processor accesses
`timescale 1ns/10ps
module fpw_far_model
(
    input wire logic i_clock,
    input wire logic i_bus_on,
    input wire logic i_pdi_on,
    output logic o_pd_exchange,
    output logic o_pdi_access
);
    logic [1:0] gap_reg; // Spacing counter, one event per kind per 4 clocks

    // Start quiet so the first edges see no stray events
    initial
    begin
        gap_reg = 2'h0;
        o_pd_exchange = 1'b0;
        o_pdi_access = 1'b0;
    end

    // Events change at the falling edge, one cycle wide, staggered so that
    // the two watchdogs never restart in the same cycle by accident
    always @(negedge i_clock)
    begin
        gap_reg <= gap_reg + 2'h1;
        o_pd_exchange <= i_bus_on && (gap_reg == 2'h0);
        o_pdi_access <= i_pdi_on && (gap_reg == 2'h2);
    end
endmodule : fpw_far_model

// ### tb/fpw_top_test.sv
// Self-checking bench of the watchdog top
`timescale 1ns/10ps
`include "fpw_cfg.svh"
module fpw_top_test
    import fpw_pkg::*;
;
    localparam int unsigned LED_CYC = 4; // Short indicator slot for sim
    localparam logic [15:0] MULT = 16'h0008; // Tick of 400 ns
    localparam logic [15:0] TIME = 16'h0005; // Five ticks per timeout
    // Last entry is an unused code, which must look like init
    localparam logic [2:0] ST[6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7};
    localparam int ONS[6] = '{0, 12, 4, 24, 12, 0}; // Lit slots out of 24

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [2:0] esm = FPW_ESM_OP;
    logic [3:0] out_in = 4'h0;
    logic bus_on = 1'b1; // Far side keeps exchanging while high
    logic pdi_on = 1'b1;
    logic [15:0] rdata;
    logic rvalid, pd_ex, pdi_acc, run_led, bus_exp, pdi_exp;
    logic [3:0] out_q, chan_led;
    integer bad_count = 0;
    integer n_compared = 0;
    integer seed = 32'h1B06;
    logic [3:0] safe;
    logic [15:0] v;
    logic [15:0] a;
    integer i, n, lo, hi;

    always #25 clock = ~clock;

    fpw_top #(.P_LED_SLOT_CYCLES(LED_CYC)) fpw_top_inst (
        .i_clock(clock), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_pd_exchange(pd_ex),
        .i_pdi_access(pdi_acc), .i_esm_state(esm), .i_out_data(out_in),
        .o_out_data(out_q), .o_chan_led(chan_led), .o_run_led(run_led),
        .o_bus_wd_expired(bus_exp), .o_pdi_wd_expired(pdi_exp)
    );

    fpw_far_model fpw_far_model_inst (
        .i_clock(clock), .i_bus_on(bus_on), .i_pdi_on(pdi_on),
        .o_pd_exchange(pd_ex), .o_pdi_access(pdi_acc)
    );

    // Compare of a register read
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h",
                $time, got, exp);
        end
    endtask : chk_reg

    // Compare of a port value or flag
    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h",
                $time, got, exp);
        end
    endtask : chk_pin

    // One write strobe, dropped at the next falling edge
    task automatic reg_wr(input logic [15:0] ad, input logic [15:0] d);
        @(negedge clock);
        wr = 1'b1;
        addr = ad;
        wdata = d;
        @(negedge clock);
        wr = 1'b0;
    endtask : reg_wr

    // One read; the answer stands for the cycle after the taking edge
    task automatic reg_rd(input logic [15:0] ad, input logic [15:0] exp);
        @(negedge clock);
        rd = 1'b1;
        addr = ad;
        @(negedge clock);
        rd = 1'b0;
        chk_pin({3'h0, rvalid}, 4'h1);
        chk_reg(rdata, exp);
    endtask : reg_rd

    // Clocks of one watchdog tick: (multiplier + 2) base ticks of 40 ns
    function automatic integer tick_cyc(input logic [15:0] m);
        return (int'(m) + 2) * int'(`FPW_BASE_TICK_NS)
            / int'(`FPW_CLK_PERIOD_NS);
    endfunction : tick_cyc

    // Stops one kind of event and counts cycles until its flag rises
    task automatic stop_wait(input logic sel, output integer cnt);
        @(posedge clock);
        if (sel)
            bus_on = 1'b0;
        else
            pdi_on = 1'b0;
        cnt = 0;
        while ((sel ? bus_exp : pdi_exp) !== 1'b1 && cnt < 80)
        begin
            @(negedge clock);
            cnt++;
        end
    endtask : stop_wait

    // Verdict and end of run, also reached from the watchdog
    task automatic end_sim();
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Cuts a hang short; the tests need under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        reg_rd(`FPW_OFF_MULT, 16'h09C2);
        reg_rd(`FPW_OFF_PDI_TIME, 16'h03E8);
        reg_rd(`FPW_OFF_BUS_TIME, 16'h03E8);
        reg_wr(`FPW_OFF_STATUS, 16'hFFFF);
        reg_rd(`FPW_OFF_STATUS, 16'h0000);
        reg_rd(16'h0404, 16'h0000);
        $display("test reset values done");
        // Random round trips; the first is the largest timer value
        for (i = 0; i < 9; i++)
        begin
            v = (i == 0) ? 16'hFFFF : 16'($random(seed));
            a = 16'h0420 - 16'(i % 3) * 16'h0010;
            reg_wr(a, v);
            reg_rd(a, v);
        end
        safe = 4'($random(seed)) | 4'h1;
        reg_wr(`FPW_OFF_SAFE_VAL, {12'hFFF, safe});
        reg_rd(`FPW_OFF_SAFE_VAL, {12'h000, safe});
        reg_wr(`FPW_OFF_MULT, MULT);
        reg_wr(`FPW_OFF_BUS_TIME, TIME);
        reg_wr(`FPW_OFF_PDI_TIME, TIME);
        $display("test register round trips done");
        // Operational pass-through while events keep coming
        for (i = 0; i < 8; i++)
        begin
            @(negedge clock);
            out_in = 4'($random(seed));
            @(negedge clock);
            chk_pin(out_q, out_in);
            chk_pin(chan_led, out_q);
        end
        repeat (100) @(negedge clock);
        chk_pin({2'h0, bus_exp, pdi_exp}, 4'h0);
        $display("test pass-through done");
        // Each watchdog in turn: expiry window, safe outputs, clearing
        lo = (int'(TIME) - 1) * tick_cyc(MULT) - 4;
        hi = int'(TIME) * tick_cyc(MULT) + 2;
        for (i = 0; i < 2; i++)
        begin
            out_in = ~safe;
            stop_wait(i == 0, n);
            chk_pin({3'h0, n >= lo && n <= hi}, 4'h1);
            @(negedge clock);
            chk_pin(out_q, safe);
            chk_pin(chan_led, safe);
            v = (i == 0) ? 16'h0002 : 16'h0001;
            reg_rd(`FPW_OFF_STATUS, v);
            @(posedge clock);
            bus_on = 1'b1;
            pdi_on = 1'b1;
            repeat (8) @(negedge clock);
            chk_pin({2'h0, bus_exp, pdi_exp}, 4'h0);
            chk_pin(out_q, out_in);
            $display("test expiry %0d done", i);
        end
        // Zero timer switches the bus watchdog off
        reg_wr(`FPW_OFF_BUS_TIME, 16'h0000);
        @(posedge clock);
        bus_on = 1'b0;
        repeat (100) @(negedge clock);
        chk_pin({3'h0, bus_exp}, 4'h0);
        $display("test disable done");
        // Safe-operational holds outputs safe
        esm = FPW_ESM_SAFEOP;
        out_in = ~safe;
        repeat (3) @(negedge clock);
        chk_pin(out_q, safe);
        // Run indicator: lit cycles over one whole pattern per state
        for (i = 0; i < 6; i++)
        begin
            esm = ST[i];
            repeat (4) @(negedge clock);
            n = 0;
            repeat (24 * LED_CYC)
            begin
                @(negedge clock);
                n = n + int'(run_led === 1'b1);
            end
            chk_reg(16'(n), 16'(ONS[i] * int'(LED_CYC)));
            chk_pin(out_q, (ST[i] == FPW_ESM_OP) ? out_in : safe);
        end
        $display("test run indicator done");
        end_sim();
    end
endmodule : fpw_top_test
